// [two_wire_status_and_data_path.sv]
// status flags, data path and byte engine of the two-wire controller
`timescale 1ns/1ps
// Notes on behaviour
// - byte done clears in transfer, sets ninth fall
// - address match sets addressed-as-slave flag
// - control write clears addressed-as-slave flag
// - start sets busy, stop clears busy
// - driven high but sampled low loses arbitration
// - start attempt on busy bus loses arbitration
// - repeated start in slave mode loses arbitration
// - unrequested stop while master loses arbitration
// - arbitration lost stays until software writes zero
// - direction flag captures calling address r/w bit
// - direction flag valid only after address match
// - byte done, match, arbitration loss set pending
// - pending and enable raise interrupt request
// - pending stays until software writes zero
// - ack bit captures data line at ninth clock
// - master-receive data read starts next byte
// - addressed slave data access lets transfer proceed
// - enable off blocks request, keeps pending flag
// - data read in rx, write in tx clear done
// - arbitration loss stops data drive, finishes byte
// - slave dummy read releases held clock line
module two_wire_status_and_data_path
  import tw_pkg::*;
#(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
  localparam logic [15:0] FULL_M1 = 16'(2 * HALF_CYC - 1);

  logic [1:0] line_s;
  reg_acc_t acc;
  logic [11:0] rd_addr;
  logic [7:0] rdata_sel;

  logic [7:0] ctrl_ff;
  logic [6:0] own_ff;
  logic done_ff, aas_ff, busy_ff, al_ff, dir_ff, pend_ff, ack_received_bit_ff;
  logic [7:0] sh_ff;
  logic [7:0] rx_ff;
  logic [3:0] bitcnt_ff;
  logic first_ff, slv_ff, shold_ff, go_ff, rsta_ff;
  logic scl_p_ff, sda_p_ff;
  mclk_state_t mc_ff, nxt_mc;
  logic [15:0] cnt_ff, nxt_cnt;
  logic mscl_ff, nxt_mscl;
  logic msda_ff, nxt_msda;
  logic sda_oe_ff, scl_oe_ff, irq_ff, line_lo_ff;

  line_sync #(.WIDTH(2)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din({scl_in, sda_in}),
    .dout(line_s)
  );

  ahb_reg_port u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .acc(acc),
    .rd_addr(rd_addr),
    .rdata(rdata_sel)
  );

  // line events seen through the synchroniser
  wire scl_s = line_s[1];
  wire sda_s = line_s[0];
  wire scl_rise = scl_s & ~scl_p_ff;
  wire scl_fall = ~scl_s & scl_p_ff;
  // our own late ack or data edge lands while scl is high: not a start
  wire sda_ours = sda_oe_ff & ((mc_ff == MC_IDLE) | (mc_ff == MC_LOW) |
                  (mc_ff == MC_HIGH));
  wire start_det = scl_s & scl_p_ff & sda_p_ff & ~sda_s & ~sda_ours;
  wire stop_det = scl_s & scl_p_ff & ~sda_p_ff & sda_s;

  // register access decode
  wire wr_ctrl = acc.wr & (acc.addr == OFS_CONTROL);
  wire wr_stat = acc.wr & (acc.addr == OFS_STATUS);
  wire wr_own = acc.wr & (acc.addr == OFS_OWN_ADDR);
  wire wr_data = acc.wr & (acc.addr == OFS_DATA);
  wire rd_data = acc.rd & (acc.addr == OFS_DATA);
  wire data_acc = wr_data | rd_data;

  wire en = ctrl_ff[CT_EN];
  wire tx = ctrl_ff[CT_TX];
  wire mstb = ctrl_ff[CT_MST];
  wire txak = ctrl_ff[CT_TXAK];

  // requests carried by a control write
  wire start_req = wr_ctrl & acc.wdata[CT_MST] & ~mstb & en;
  wire stop_req = wr_ctrl & ~acc.wdata[CT_MST] & mstb;
  wire rsta_req = wr_ctrl & acc.wdata[CT_RSTA];
  wire start_busy = start_req & busy_ff;
  wire rsta_slave = rsta_req & ~mstb;

  // byte framing
  wire in_data = bitcnt_ff < BITS_PER_BYTE;
  wire at_ack = bitcnt_ff == BITS_PER_BYTE;
  wire byte_end = scl_fall & (bitcnt_ff == LAST_RISE);
  wire addr_match = first_ff & ~mstb & en &
                    (sh_ff[7:1] == own_ff);

  // what this end drives low on sda during the low half of scl
  wire active_tx = en & tx & (mstb | slv_ff);
  wire ack_low = first_ff ? addr_match :
                 (en & ~tx & (mstb | slv_ff) & ~txak);
  wire drv_low = in_data ? (active_tx & ~sh_ff[7]) : (at_ack & ack_low);

  // master meant high but the line reads low
  wire want_high = mstb & ((in_data & tx & sh_ff[7]) |
                   (at_ack & ~tx & ~first_ff & txak));
  wire al_sda = scl_rise & want_high & ~sda_s;
  wire stop_foreign = stop_det & mstb;
  wire al_set = al_sda | start_busy | rsta_slave | stop_foreign;

  // sequencer states in which the master owns sda timing
  wire seq_sda = (mc_ff == MC_START) | (mc_ff == MC_STOP1) |
                 (mc_ff == MC_STOP2) | (mc_ff == MC_RSTA);

  // read data selection
  wire [7:0] status_rd = {done_ff, aas_ff, busy_ff, al_ff, 1'b0,
                          dir_ff, pend_ff, ack_received_bit_ff};
  assign rdata_sel = (rd_addr == OFS_STATUS) ? status_rd :
                     (rd_addr == OFS_CONTROL) ? ctrl_ff :
                     (rd_addr == OFS_OWN_ADDR) ? {own_ff, 1'b0} :
                     (rd_addr == OFS_DATA) ? rx_ff : 8'h00;

  // control register; hardware drops master on arbitration loss
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CONTROL_RST;
      own_ff <= OWN_ADDR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= acc.wdata & CONTROL_MASK & ~(8'h01 << CT_RSTA);
      end
      if (al_set) begin
        ctrl_ff[CT_MST] <= 1'b0;
      end
      if (wr_own) begin
        own_ff <= acc.wdata[7:1];
      end
    end
  end

  // status flags: hardware sets always win over clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {done_ff, aas_ff, busy_ff, al_ff} <= STATUS_RST[7:4];
      {dir_ff, pend_ff, ack_received_bit_ff} <= STATUS_RST[2:0];
    end else begin
      // writes to the status word only reach lost and pending
      if ((scl_rise & bitcnt_ff == '0) | (rd_data & ~tx) |
          (wr_data & tx)) begin
        done_ff <= 1'b0;
      end
      if (byte_end) begin
        done_ff <= 1'b1;
      end
      if (wr_ctrl | (scl_rise & bitcnt_ff == '0 & ~first_ff)) begin
        aas_ff <= 1'b0;
      end
      if (byte_end & addr_match) begin
        aas_ff <= 1'b1;
        dir_ff <= sh_ff[0];
      end
      if (stop_det) begin
        busy_ff <= 1'b0;
      end
      if (start_det) begin
        busy_ff <= 1'b1;
      end
      if (wr_stat & ~acc.wdata[ST_AL]) begin
        al_ff <= 1'b0;
      end
      if (al_set) begin
        al_ff <= 1'b1;
      end
      if (wr_stat & ~acc.wdata[ST_PEND]) begin
        pend_ff <= 1'b0;
      end
      if (byte_end | al_set) begin
        pend_ff <= 1'b1;
      end
      // taken as the ninth clock falls, once a late own ack has settled
      if (byte_end) begin
        ack_received_bit_ff <= sda_s;
      end
    end
  end

  // interrupt request follows pending gated by the enable bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= pend_ff & ctrl_ff[CT_IE];
    end
  end

  // shift register doubles as transmit and receive path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_ff <= '0;
      rx_ff <= '0;
      bitcnt_ff <= '0;
      first_ff <= 1'b0;
      scl_p_ff <= 1'b1;
      sda_p_ff <= 1'b1;
    end else begin
      scl_p_ff <= scl_s;
      sda_p_ff <= sda_s;
      if (wr_data) begin
        sh_ff <= acc.wdata;
      end else if (scl_rise & in_data) begin
        sh_ff <= {sh_ff[6:0], sda_s};
      end
      if (byte_end) begin
        rx_ff <= sh_ff;
      end
      if (start_det) begin
        bitcnt_ff <= '0;
        first_ff <= 1'b1;
      end else if (byte_end) begin
        bitcnt_ff <= '0;
        first_ff <= 1'b0;
      end else if (scl_rise & bitcnt_ff != LAST_RISE) begin
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end
    end
  end

  // slave side: addressed state and clock stretching after each byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slv_ff <= 1'b0;
      shold_ff <= 1'b0;
    end else begin
      if (start_det | stop_det | ~en) begin
        slv_ff <= 1'b0;
      end else if (byte_end & addr_match) begin
        slv_ff <= 1'b1;
      end
      // hold scl low until software touches the data register
      if (data_acc | stop_det | ~en) begin
        shold_ff <= 1'b0;
      end else if (byte_end & ~mstb & (slv_ff | addr_match)) begin
        shold_ff <= 1'b1;
      end
    end
  end

  // go and repeated-start requests wait for the sequencer to pick them up;
  // a go left over from slave traffic is dropped while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_ff <= 1'b0;
      rsta_ff <= 1'b0;
    end else begin
      if (data_acc) begin
        go_ff <= 1'b1;
      end else if ((mc_ff == MC_HOLD & go_ff) | mc_ff == MC_IDLE) begin
        go_ff <= 1'b0;
      end
      if (rsta_req & mstb) begin
        rsta_ff <= 1'b1;
      end else if (mc_ff == MC_RSTA | ~mstb) begin
        rsta_ff <= 1'b0;
      end
    end
  end

  // master clock sequencer; high half waits while others stretch scl
  always_comb begin
    nxt_mc = mc_ff;
    nxt_cnt = cnt_ff + 16'h1;
    nxt_mscl = mscl_ff;
    nxt_msda = msda_ff;
    case (mc_ff)
      MC_IDLE: begin
        nxt_cnt = '0;
        nxt_mscl = 1'b0;
        nxt_msda = 1'b0;
        if (start_req & ~busy_ff) begin
          nxt_mc = MC_START;
          nxt_msda = 1'b1;
        end
      end
      MC_START: begin
        if (cnt_ff == HALF_M1) begin
          nxt_mc = MC_HOLD;
          nxt_mscl = 1'b1;
          nxt_cnt = '0;
        end
      end
      MC_HOLD: begin
        nxt_cnt = '0;
        if (~mstb) begin
          nxt_mc = al_ff ? MC_IDLE : MC_STOP1;
          nxt_mscl = ~al_ff;
        end else if (rsta_ff) begin
          nxt_mc = MC_RSTA;
          nxt_msda = 1'b0;
        end else if (go_ff) begin
          nxt_mc = MC_LOW;
        end
      end
      MC_LOW: begin
        if (cnt_ff == HALF_M1) begin
          nxt_mc = MC_HIGH;
          nxt_mscl = 1'b0;
          nxt_cnt = '0;
        end
      end
      MC_HIGH: begin
        if (!scl_s) begin
          nxt_cnt = '0;
        end else if (cnt_ff == HALF_M1) begin
          nxt_cnt = '0;
          nxt_mscl = 1'b1;
          // a lost master still clocks out the rest of the byte
          if (bitcnt_ff != LAST_RISE) begin
            nxt_mc = MC_LOW;
          end else if (~mstb & al_ff) begin
            nxt_mc = MC_IDLE;
            nxt_mscl = 1'b0;
          end else begin
            nxt_mc = MC_HOLD;
          end
        end
      end
      MC_STOP1: begin
        nxt_msda = 1'b1;
        if (cnt_ff == HALF_M1) begin
          nxt_mc = MC_STOP2;
          nxt_mscl = 1'b0;
          nxt_cnt = '0;
        end
      end
      MC_STOP2: begin
        if (!scl_s) begin
          nxt_cnt = '0;
        end else if (cnt_ff == HALF_M1) begin
          nxt_mc = MC_IDLE;
          nxt_msda = 1'b0;
        end
      end
      MC_RSTA: begin
        nxt_mscl = cnt_ff < 16'(HALF_CYC);
        if (cnt_ff == FULL_M1) begin
          nxt_mc = MC_START;
          nxt_msda = 1'b1;
          nxt_cnt = '0;
        end
      end
      default: begin
        nxt_mc = MC_IDLE;
        nxt_mscl = 1'b0;
        nxt_msda = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_ff <= MC_IDLE;
      cnt_ff <= '0;
      mscl_ff <= 1'b0;
      msda_ff <= 1'b0;
    end else begin
      mc_ff <= nxt_mc;
      cnt_ff <= nxt_cnt;
      mscl_ff <= nxt_mscl;
      msda_ff <= nxt_msda;
    end
  end

  // open-drain drivers; data bits only change while scl is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      line_lo_ff <= 1'b0;
    end else begin
      scl_oe_ff <= en & (mscl_ff | shold_ff);
      if (!en) begin
        sda_oe_ff <= 1'b0;
      end else if (seq_sda) begin
        sda_oe_ff <= msda_ff;
      end else if (!scl_s) begin
        sda_oe_ff <= drv_low;
      end
    end
  end

  assign scl_out = line_lo_ff;
  assign sda_out = line_lo_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign irq = irq_ff;

endmodule

// [tw_pkg.sv]
// shared constants, types and register map of the two-wire status block
package tw_pkg;

  // register byte offsets within the block
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_OWN_ADDR = 12'h280;
  localparam logic [11:0] OFS_CONTROL = 12'h288;
  localparam logic [11:0] OFS_STATUS = 12'h28c;
  localparam logic [11:0] OFS_DATA = 12'h290;

  // status field positions
  localparam int ST_DONE = 7;
  localparam int ST_AAS = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_AL = 4;
  localparam int ST_DIR = 2;
  localparam int ST_PEND = 1;
  localparam int ST_ACK_RECEIVED_BIT = 0;

  // control field positions
  localparam int CT_EN = 7;
  localparam int CT_IE = 6;
  localparam int CT_MST = 5;
  localparam int CT_TX = 4;
  localparam int CT_TXAK = 3;
  localparam int CT_RSTA = 2;

  // reset values and control write mask
  localparam logic [7:0] STATUS_RST = 8'h81;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  localparam logic [7:0] CONTROL_MASK = 8'hf8;

  // byte framing on the wire
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_RISE = 4'h9;

  // timing of the generated bus clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;

  // bus constants
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [23:0] RDATA_PAD = 24'h00_0000;

  // master clock sequencer, gray along idle-start-hold-low-high
  typedef enum logic [2:0] {
    MC_IDLE = 3'h0,
    MC_START = 3'h1,
    MC_HOLD = 3'h3,
    MC_LOW = 3'h2,
    MC_HIGH = 3'h6,
    MC_STOP1 = 3'h7,
    MC_STOP2 = 3'h5,
    MC_RSTA = 3'h4
  } mclk_state_t;

  // one register access, a single-cycle pulse
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_acc_t;

endpackage

// [line_sync.sv]
// three-flop synchroniser with agreement filter for the bus lines
`timescale 1ns/1ps
module line_sync
  import tw_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // lines idle high, so every stage resets high
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic out_ff;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff <= 1'b1;
          s2_ff <= 1'b1;
          s3_ff <= 1'b1;
          out_ff <= 1'b1;
        end else begin
          s1_ff <= din[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          // a change counts only once two stages agree
          if (s2_ff == s3_ff) begin
            out_ff <= s3_ff;
          end
        end
      end
      assign dout[i] = out_ff;
    end
  endgenerate

endmodule

// [ahb_reg_port.sv]
// ahb-lite slave front end: one wait state, single-cycle access pulse
`timescale 1ns/1ps
module ahb_reg_port
  import tw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output reg_acc_t acc,
  output logic [11:0] rd_addr,
  input wire logic [7:0] rdata
);

  logic pend_ff;
  logic wr_ff;
  logic [11:0] addr_ff;
  logic ready_ff;
  logic [31:0] rdata_ff;
  reg_acc_t acc_ff;

  // only whole-word transfers are issued, so hsize needs no decode
  wire take = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;

  // the wait state lets read data come from a flop, not from decode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= '0;
      ready_ff <= 1'b1;
      rdata_ff <= '0;
      acc_ff <= '0;
    end else begin
      acc_ff <= '0;
      if (pend_ff) begin
        pend_ff <= 1'b0;
        ready_ff <= 1'b1;
        acc_ff <= '{wr: wr_ff, rd: ~wr_ff, addr: addr_ff,
                    wdata: hwdata[7:0]};
        rdata_ff <= wr_ff ? '0 : {RDATA_PAD, rdata};
      end else if (take) begin
        pend_ff <= 1'b1;
        wr_ff <= hwrite;
        addr_ff <= haddr[ADDR_W-1:0];
        ready_ff <= 1'b0;
      end
    end
  end

  assign hreadyout = ready_ff;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_ff;
  assign acc = acc_ff;
  assign rd_addr = addr_ff;

endmodule

// [tw_status_asserts.sv]
// port-level checker for the two-wire status block, bound to its top
`timescale 1ns/1ps
module tw_status_checker
  import tw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic dph_ff, wr_ff, en_ff, ie_ff;
  logic [11:0] adr_ff;
  logic [3:0] since_ff;
  // transfer bookkeeping seen from the bus side only
  wire taken = hsel && htrans[1] && hready;
  wire done_w = dph_ff && hreadyout;
  wire rd_done = done_w && !wr_ff;
  wire ctl_wr = done_w && wr_ff && adr_ff == OFS_CONTROL;
  wire flag_wr = ctl_wr || (done_w && wr_ff && adr_ff == OFS_STATUS);
  wire mapped = adr_ff == OFS_OWN_ADDR || adr_ff == OFS_CONTROL ||
                adr_ff == OFS_STATUS || adr_ff == OFS_DATA;
  wire [3:0] nxt_since = flag_wr ? 4'h0 :
                         (since_ff == 4'hf) ? since_ff : since_ff + 4'h1;
  // data phase tracker; a new address phase wins over completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      wr_ff <= 1'b0;
      adr_ff <= 12'h000;
    end else if (taken) begin
      dph_ff <= 1'b1;
      wr_ff <= hwrite;
      adr_ff <= haddr[11:0];
    end else if (hreadyout) begin
      dph_ff <= 1'b0;
    end
  end
  // shadow of enable bits and age of the last flag-touching write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ff <= 1'b0;
      ie_ff <= 1'b0;
      since_ff <= 4'hf;
    end else begin
      en_ff <= ctl_wr ? hwdata[CT_EN] : en_ff;
      ie_ff <= ctl_wr ? hwdata[CT_IE] : ie_ff;
      since_ff <= nxt_since;
    end
  end
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response other than okay");
  chk_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("transfer not answered after one wait state");
  chk_rdata_pad: assert property (rd_done |-> hrdata[31:8] == RDATA_PAD)
    else $error("upper read data not zero");
  chk_unmapped_zero: assert property (rd_done && !mapped |-> hrdata == 0)
    else $error("unmapped read not zero");
  chk_status_rsvd: assert property (rd_done && adr_ff == OFS_STATUS |->
    hrdata[3] == 1'b0) else $error("reserved status bit set");
  chk_rsta_reads0: assert property (rd_done && adr_ff == OFS_CONTROL |->
    hrdata[CT_RSTA] == 1'b0 && hrdata[1:0] == 2'b00)
    else $error("control write-only bits read nonzero");
  chk_irq_needs_en: assert property ($rose(irq) |-> ie_ff || $past(ie_ff, 3))
    else $error("interrupt raised while disabled");
  chk_irq_blocked: assert property (!ie_ff [*4] |-> !irq)
    else $error("interrupt not blocked by enable off");
  chk_irq_sticky: assert property ($fell(irq) |-> since_ff < 4'h8)
    else $error("interrupt dropped without software write");
  chk_pend_to_irq: assert property (rd_done && adr_ff == OFS_STATUS &&
    hrdata[ST_PEND] && ie_ff |-> ##[0:3] irq)
    else $error("pending flag without interrupt request");
  chk_off_no_drive: assert property (!en_ff [*4] |-> !scl_oe && !sda_oe)
    else $error("lines driven while disabled");
  cover property (rd_done && adr_ff == OFS_STATUS && hrdata[ST_AL]);
  cover property ($fell(scl_oe));
  cover property ($rose(irq));
endmodule

bind two_wire_status_and_data_path tw_status_checker u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .scl_oe(scl_oe),
  .sda_oe(sda_oe),
  .irq(irq)
);

// [tw_far_master.sv]
// far-side bus master model on the shared clock and data lines
`timescale 1ns/1ps
module tw_far_master (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_low,
  output logic sda_low
);
  localparam int HALF_NS = 80;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // release clock, wait while a slave stretches it (bounded)
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 9000 && scl_w !== 1'b1; i++) #3;
  endtask
  // data falls while the clock is high
  task automatic start();
    #7;
    sda_low = 1'b1;
    #HALF_NS;
    scl_low = 1'b1;
    #HALF_NS;
  endtask
  // msb first; ninth bit released so the receiver answers
  task automatic send(input logic [7:0] b, output logic ack);
    logic [8:0] sh;
    sh = {b, 1'b1};
    for (int i = 0; i < 9; i++) begin
      #23;
      sda_low = !sh[8];
      sh = sh << 1;
      #57;
      rise();
      #67;
      ack = sda_w;
      #13;
      scl_low = 1'b1;
    end
  endtask
  // data rises while the clock is high
  task automatic stop();
    #23;
    sda_low = 1'b1;
    #57;
    rise();
    #HALF_NS;
    sda_low = 1'b0;
    #HALF_NS;
  endtask
endmodule

// [tb_two_wire_status_and_data_path.sv]
// self-checking bench for the two-wire status and data block
`timescale 1ns/1ps
module tb_two_wire_status_and_data_path
  import tw_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic scl_out, scl_oe, sda_out, sda_oe, scl_low, sda_low, ack;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  // open-drain lines with pull-ups
  wire scl_w = !(scl_oe || scl_low);
  wire sda_w = !(sda_oe || sda_low);
  two_wire_status_and_data_path #(.HALF_CYC(5)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
  );
  tw_far_master fm (
    .scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low)
  );
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // whole run is a few hundred cycles; this only cuts a hang
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single ahb-lite transfer; read data lands in rv
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  // read a register and compare the bits under mask, upper bits zero
  task automatic rc(input string n, input logic [11:0] a,
                    input logic [7:0] e, input logic [7:0] m);
    xfer(1'b0, a, 8'h00);
    chk(n, {24'h00_0000, e & m}, rv & {24'hff_ffff, m});
  endtask
  // poll status until a bit reaches a value, bounded
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 60; i++) begin
      xfer(1'b0, OFS_STATUS, 8'h00);
      if (rv[b] === v) break;
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rc("status reset", OFS_STATUS, STATUS_RST, 8'hff);
    rc("control reset", OFS_CONTROL, CONTROL_RST, 8'hff);
    xfer(1'b1, OFS_STATUS, 8'hff);
    rc("status ro", OFS_STATUS, 8'h81, 8'hff);
    xfer(1'b0, 12'h2a0, 8'h00);
    chk("unmapped", 32'h0000_0000, rv);
    xfer(1'b1, OFS_OWN_ADDR, 8'h54);
    xfer(1'b1, OFS_CONTROL, 8'hc0);
    fm.start();
    poll(ST_BUSY, 1'b1);
    rc("busy on start", OFS_STATUS, 8'ha1, 8'hff);
    xfer(1'b1, OFS_CONTROL, 8'he0);
    rc("start when busy", OFS_STATUS, 8'hb3, 8'hff);
    chk("irq on loss", 32'h1, {31'h0, irq});
    xfer(1'b1, OFS_STATUS, 8'hff);
    rc("flags stay", OFS_STATUS, 8'hb3, 8'hff);
    xfer(1'b1, OFS_CONTROL, 8'h80);
    repeat (3) @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rc("pend kept", OFS_STATUS, 8'hb3, 8'hff);
    xfer(1'b1, OFS_STATUS, 8'h00);
    xfer(1'b1, OFS_CONTROL, 8'hc4);
    rc("restart as slave", OFS_STATUS, 8'hb3, 8'hff);
    xfer(1'b1, OFS_STATUS, 8'h00);
    rc("flags cleared", OFS_STATUS, 8'ha1, 8'hff);
    fm.send(8'h54, ack);
    chk("addr ack", 32'h0, {31'h0, ack});
    poll(ST_DONE, 1'b1);
    rc("addressed", OFS_STATUS, 8'he2, 8'hff);
    chk("irq on match", 32'h1, {31'h0, irq});
    chk("scl held", 32'h1, {31'h0, scl_oe});
    xfer(1'b1, OFS_STATUS, 8'h00);
    repeat (3) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b1, OFS_CONTROL, 8'hc0);
    rc("match cleared", OFS_STATUS, 8'ha0, 8'hff);
    xfer(1'b0, OFS_DATA, 8'h00);
    repeat (3) @(posedge hclk);
    chk("scl freed", 32'h0, {31'h0, scl_oe});
    chk("line lows", 32'h0, {30'h0, scl_out, sda_out});
    rc("done cleared", OFS_STATUS, 8'h20, 8'hfb);
    // first byte acknowledged, second refused by the no-ack bit
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, OFS_CONTROL, k ? 8'hc8 : 8'hc0);
      fm.send(k ? 8'h3c : 8'ha5, ack);
      chk("data ack", {31'h0, k[0]}, {31'h0, ack});
      poll(ST_DONE, 1'b1);
      rc("byte done", OFS_STATUS, k ? 8'ha3 : 8'ha2, 8'hfb);
      xfer(1'b1, OFS_STATUS, 8'h00);
      rc("rx data", OFS_DATA, k ? 8'h3c : 8'ha5, 8'hff);
    end
    fm.stop();
    poll(ST_BUSY, 1'b0);
    rc("busy off", OFS_STATUS, 8'h01, 8'hfb);
    give_verdict();
  end
endmodule
